// ---- common/rbds_pkg.sv ----
package rbds_pkg;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int BOOT_MIN_MS = 200;
    localparam int SETTLE_CYCLES = BOOT_MIN_MS * 1000 * CLK_MHZ;

    // reset fetch and memory map
    localparam logic [23:0] RESET_VECTOR = 24'hFFFF00;
    localparam logic ROM_MAP_DEFAULT = 1'h0;
    localparam logic [4:0] SCRATCH_BLOCK = 5'h1F;
    localparam int SCRATCH_AW = 4;
    localparam logic [SCRATCH_AW-1:0] SIG_BYTES = 4'h2;
    // arbitrary value, replace with the real boot signature
    localparam logic [15:0] BOOT_SIG_DEFAULT = 16'hA55A;

    // clock generator multipliers
    localparam logic [10:0] PLL_MULT_RTC = 11'h177;
    localparam logic [10:0] PLL_MULT_RTC_FAST = 11'h465;
    localparam logic [10:0] PLL_MULT_EXT_FAST = 11'h003;

    // probe settings
    localparam logic [1:0] SPI_CHIP_SEL = 2'h0;
    localparam logic [9:0] SPI_CLK_KHZ = 10'h1F4;
    localparam logic [9:0] I2C_CLK_KHZ = 10'h190;
    localparam logic [6:0] I2C_TARGET = 7'h50;
    localparam logic [16:0] UART_BAUD = 17'h0E100;
    localparam logic [3:0] UART_DATA_BITS = 4'h8;
    localparam logic [1:0] UART_STOP_BITS = 2'h1;
    localparam logic UART_PARITY_ODD = 1'h1;
    localparam logic UART_FLOW_CTRL = 1'h1;
    localparam logic [3:0] USB_BOOT_EP = 4'h1;

    // peripheral clock enable bits
    localparam int PCLK_W = 5;
    localparam logic [PCLK_W-1:0] PCLK_SPI = 5'h01;
    localparam logic [PCLK_W-1:0] PCLK_I2C = 5'h02;
    localparam logic [PCLK_W-1:0] PCLK_MMC = 5'h04;
    localparam logic [PCLK_W-1:0] PCLK_UART = 5'h08;
    localparam logic [PCLK_W-1:0] PCLK_USB = 5'h10;

    typedef enum logic [14:0] {
        ST_VECTOR = 15'h0001,
        ST_SLEW = 15'h0002,
        ST_IDLE = 15'h0004,
        ST_CLOCK = 15'h0008,
        ST_TRIM = 15'h0010,
        ST_PROBE = 15'h0020,
        ST_WAITP = 15'h0040,
        ST_RD0 = 15'h0080,
        ST_RD1 = 15'h0100,
        ST_CHECK = 15'h0200,
        ST_CONFIG = 15'h0400,
        ST_COPY = 15'h0800,
        ST_RETUNE = 15'h1000,
        ST_SETTLE = 15'h2000,
        ST_DONE = 15'h4000
    } rbds_state_e;

    // probe order is the numeric order up to SRC_USB, then SRC_UART and SRC_USB alternate
    typedef enum logic [2:0] {
        SRC_SPI16 = 3'h0,
        SRC_SPI24 = 3'h1,
        SRC_I2C = 3'h2,
        SRC_EMMC_PART = 3'h3,
        SRC_EMMC = 3'h4,
        SRC_SD = 3'h5,
        SRC_UART = 3'h6,
        SRC_USB = 3'h7
    } rbds_src_e;

    typedef struct packed {
        logic byte_valid;
        logic [7:0] byte_data;
        logic probe_done;
        logic cfg_present;
        logic cfg_done;
        logic copy_done;
        logic [23:0] entry_point;
    } rbds_feed_s;

    typedef struct packed {
        logic req;
        rbds_src_e src;
        logic addr_24bit;
        logic [1:0] chip_sel;
        logic [6:0] target;
        logic [9:0] bus_khz;
        logic [16:0] baud;
        logic [3:0] data_bits;
        logic [1:0] stop_bits;
        logic parity_odd;
        logic flow_ctrl;
        logic [3:0] endpoint;
    } rbds_probe_s;

    typedef struct packed {
        logic vector_fetch;
        logic [23:0] fetch_addr;
        logic rom_mapping_select;
        logic pll_bypass;
        logic [10:0] pll_mult;
        logic clock_output_pin_slow;
        logic clock_output_pin_enable;
        logic periph_idle;
        logic memory_port_idle;
        logic hardware_accelerator_idle;
        logic bandgap_trim_load;
        logic [PCLK_W-1:0] periph_clk;
        logic usb_ldo_en;
        logic cfg_req;
        logic copy_req;
        logic jump;
        logic [23:0] jump_addr;
        logic scratch_reserved;
        logic [4:0] scratch_block;
    } rbds_ctrl_s;

    function automatic rbds_src_e next_src(input rbds_src_e s);
        if (s == SRC_USB)
        begin
            return SRC_UART;
        end
        if (s == SRC_UART)
        begin
            return SRC_USB;
        end
        return rbds_src_e'(s + 3'h1);
    endfunction

    function automatic logic [PCLK_W-1:0] periph_of(input rbds_src_e s);
        unique case (s)
            SRC_SPI16, SRC_SPI24: periph_of = PCLK_SPI;
            SRC_I2C: periph_of = PCLK_I2C;
            SRC_EMMC_PART, SRC_EMMC, SRC_SD: periph_of = PCLK_MMC;
            SRC_UART: periph_of = PCLK_UART;
            SRC_USB: periph_of = PCLK_USB;
        endcase
    endfunction

endpackage

// ---- logic/rbds_settle_timer.sv ----
`timescale 1ns/1ps
module rbds_settle_timer
    import rbds_pkg::*;
#(
    parameter int CYCLES = SETTLE_CYCLES,
    parameter int W = $clog2(CYCLES + 1)
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] count;
        logic running;
        logic expired;
    } rbds_tmr_s;

    rbds_tmr_s tmr;
    rbds_tmr_s next_tmr;

    always_comb
    begin
        next_tmr = tmr;
        // a restart drops the old result so a retune is timed afresh
        if (start)
        begin
            next_tmr.count = W'(CYCLES - 1);
            next_tmr.running = 1'h1;
            next_tmr.expired = 1'h0;
        end
        else if (tmr.running)
        begin
            if (tmr.count == '0)
            begin
                next_tmr.running = 1'h0;
                next_tmr.expired = 1'h1;
            end
            else
            begin
                next_tmr.count = tmr.count - W'(1);
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tmr <= '0;
        end
        else
        begin
            tmr <= next_tmr;
        end
    end

    assign expired = tmr.expired;

    a_start_clears: assert property (@(posedge clock) disable iff (sys_rst) // R15
        start |=> !expired)
        else $error("settle timer kept expired after restart");
    a_expired_holds: assert property (@(posedge clock) disable iff (sys_rst) // R19
        expired && !start |=> expired)
        else $error("settle timer dropped expired without restart");
endmodule

// ---- logic/rbds_scratch_ram.sv ----
`timescale 1ns/1ps
module rbds_scratch_ram
    import rbds_pkg::*;
#(
    parameter int AW = SCRATCH_AW,
    parameter int DW = 8
)(
    input wire logic clock,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    typedef struct packed {
        logic [(1 << AW)-1:0][DW-1:0] mem;
        logic [DW-1:0] rdata;
    } rbds_ram_s;

    rbds_ram_s ram;
    rbds_ram_s next_ram;

    always_comb
    begin
        next_ram = ram;
        if (we)
        begin
            next_ram.mem[waddr] = wdata;
        end
        next_ram.rdata = ram.mem[raddr];
    end

    // contents need no reset, readers always write before they read
    always_ff @(posedge clock)
    begin
        ram <= next_ram;
    end

    assign rdata = ram.rdata;

    a_read_back: assert property (@(posedge clock) // R23
        $past(we) && raddr == $past(waddr) |=> rdata == $past(wdata, 2))
        else $error("scratch read did not return written byte");
endmodule

// ---- logic/rbds_sequencer.sv ----
`timescale 1ns/1ps
// Overview of operation
// R1: fetch vector from top, ROM mapped, bypass
// R2: boot starts by itself after reset
// R3: probe sources in fixed priority order
// R4: first valid signature wins, skip rest
// R5: nothing valid: loop serial until reset
// R6: slow clock pin slew, idle domains
// R7: strap picks PLL 375x or bypass
// R8: start settle timer after clock setup
// R9: load bandgap trim, then stop clock pin
// R10: SPI chip select 0, 500 kHz, 16-bit
// R11: retry SPI 24-bit, then try I2C
// R12: apply register section before image load
// R13: I2C target 0x50 at 400 kHz
// R14: cards carry FAT or boot partition image
// R15: retune PLL near 36 MHz, restart timer
// R16: UART 57600 8O1, flow control
// R17: USB regulator on, image on endpoint 1
// R18: poll UART and USB in turns
// R19: copy, wait 200 ms, then jump
// R20: peripheral clock only while probing it
// R21: at handoff clocks off, domains idled
// R22: image config leaves PLL and timer alone
// R23: scratch block 31 reserved during boot
// R24: signature is a configurable constant
module rbds_sequencer
    import rbds_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES,
    parameter logic [15:0] BOOT_SIGNATURE = BOOT_SIG_DEFAULT
)(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_source_select,
    input wire rbds_feed_s feed,
    output rbds_ctrl_s ctrl,
    output rbds_probe_s probe
);
    typedef struct packed {
        rbds_state_e st;
        rbds_src_e src;
        logic sel_meta;
        logic sel_sync;
        logic clk_sel;
        logic [SCRATCH_AW-1:0] wr_ptr;
        logic [SCRATCH_AW-1:0] rd_addr;
        logic [7:0] sig_hi;
        logic tmr_start;
        rbds_ctrl_s ctrl;
        rbds_probe_s probe;
    } rbds_seq_s;

    rbds_seq_s seq;
    rbds_seq_s next_seq;
    logic [7:0] scratch_rdata;
    logic settle_done;
    logic sig_match;
    logic scratch_we;

    assign scratch_we = (seq.st == ST_WAITP) && feed.byte_valid && (seq.wr_ptr != '1);

    // R24: signature compare
    assign sig_match = (seq.wr_ptr >= SIG_BYTES)
        && ({seq.sig_hi, scratch_rdata} == BOOT_SIGNATURE);

    // R23: header bytes land in scratch
    rbds_scratch_ram #(
        .AW(SCRATCH_AW),
        .DW(8)
    ) u_scratch (
        .clock(clock),
        .we(scratch_we),
        .waddr(seq.wr_ptr),
        .wdata(feed.byte_data),
        .raddr(seq.rd_addr),
        .rdata(scratch_rdata)
    );

    rbds_settle_timer #(
        .CYCLES(SETTLE)
    ) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(seq.tmr_start),
        .expired(settle_done)
    );

    always_comb
    begin
        next_seq = seq;
        next_seq.sel_meta = clock_source_select;
        next_seq.sel_sync = seq.sel_meta;
        next_seq.tmr_start = 1'h0;
        next_seq.ctrl.vector_fetch = 1'h0;
        next_seq.ctrl.bandgap_trim_load = 1'h0;
        next_seq.ctrl.cfg_req = 1'h0;
        next_seq.ctrl.copy_req = 1'h0;
        next_seq.ctrl.jump = 1'h0;
        next_seq.probe.req = 1'h0;
        unique case (seq.st)
            ST_VECTOR:
            begin
                // R1: reset vector fetch
                next_seq.ctrl.vector_fetch = 1'h1;
                next_seq.st = ST_SLEW;
            end
            ST_SLEW:
            begin
                // R6: slow clock pin edges
                next_seq.ctrl.clock_output_pin_slow = 1'h1;
                next_seq.st = ST_IDLE;
            end
            ST_IDLE:
            begin
                // R6: idle the domains
                next_seq.ctrl.periph_idle = 1'h1;
                next_seq.ctrl.memory_port_idle = 1'h1;
                next_seq.ctrl.hardware_accelerator_idle = 1'h1;
                next_seq.st = ST_CLOCK;
            end
            ST_CLOCK:
            begin
                // R7: strap taken after sync
                next_seq.clk_sel = seq.sel_sync;
                if (!seq.sel_sync)
                begin
                    next_seq.ctrl.pll_bypass = 1'h0;
                    next_seq.ctrl.pll_mult = PLL_MULT_RTC;
                end
                // R8: settle timer start
                next_seq.tmr_start = 1'h1;
                next_seq.ctrl.bandgap_trim_load = 1'h1;
                next_seq.st = ST_TRIM;
            end
            ST_TRIM:
            begin
                // R9: clock pin off after trim
                next_seq.ctrl.clock_output_pin_enable = 1'h0;
                next_seq.st = ST_PROBE;
            end
            ST_PROBE:
            begin
                // R10: per-source probe setup
                next_seq.probe.req = 1'h1;
                next_seq.probe.src = seq.src;
                next_seq.probe.addr_24bit = (seq.src == SRC_SPI24);
                // R13: i2c bus rate
                next_seq.probe.bus_khz = (seq.src == SRC_I2C) ? I2C_CLK_KHZ : SPI_CLK_KHZ;
                // R20: clock only the probed unit
                next_seq.ctrl.periph_clk = periph_of(seq.src);
                next_seq.wr_ptr = '0;
                next_seq.st = ST_WAITP;
            end
            ST_WAITP:
            begin
                if (scratch_we)
                begin
                    next_seq.wr_ptr = seq.wr_ptr + SCRATCH_AW'(1);
                end
                if (feed.probe_done)
                begin
                    next_seq.rd_addr = '0;
                    next_seq.st = ST_RD0;
                end
            end
            ST_RD0:
            begin
                next_seq.rd_addr = SCRATCH_AW'(1);
                next_seq.st = ST_RD1;
            end
            ST_RD1:
            begin
                next_seq.sig_hi = scratch_rdata;
                next_seq.st = ST_CHECK;
            end
            ST_CHECK:
            begin
                if (sig_match)
                begin
                    // R4: first valid source is used
                    // R12: register section goes first
                    if (feed.cfg_present)
                    begin
                        next_seq.ctrl.cfg_req = 1'h1;
                        next_seq.st = ST_CONFIG;
                    end
                    else
                    begin
                        next_seq.ctrl.copy_req = 1'h1;
                        next_seq.st = ST_COPY;
                    end
                end
                else
                begin
                    // R3: advance in priority order
                    // R11: spi 24-bit retry then i2c
                    // R18: serial sources alternate
                    next_seq.ctrl.periph_clk = '0;
                    next_seq.src = next_src(seq.src);
                    // R5: serial fallback after last card
                    next_seq.st = (seq.src == SRC_SD) ? ST_RETUNE : ST_PROBE;
                end
            end
            ST_CONFIG:
            begin
                if (feed.cfg_done)
                begin
                    next_seq.ctrl.copy_req = 1'h1;
                    next_seq.st = ST_COPY;
                end
            end
            ST_COPY:
            begin
                if (feed.copy_done)
                begin
                    next_seq.ctrl.jump_addr = feed.entry_point;
                    // R21: clocks off before handoff
                    next_seq.ctrl.periph_clk = '0;
                    next_seq.st = ST_SETTLE;
                end
            end
            ST_RETUNE:
            begin
                // R15: faster clock for serial boot
                next_seq.ctrl.pll_bypass = 1'h0;
                next_seq.ctrl.pll_mult = seq.clk_sel ? PLL_MULT_EXT_FAST : PLL_MULT_RTC_FAST;
                next_seq.tmr_start = 1'h1;
                // R17: usb regulator up
                next_seq.ctrl.usb_ldo_en = 1'h1;
                next_seq.st = ST_PROBE;
            end
            ST_SETTLE:
            begin
                // R19: hold until minimum time
                if (settle_done)
                begin
                    next_seq.ctrl.jump = 1'h1;
                    next_seq.ctrl.scratch_reserved = 1'h0;
                    next_seq.st = ST_DONE;
                end
            end
            ST_DONE:
            begin
                next_seq.st = ST_DONE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            // R2: boot flow armed by reset alone
            seq <= '0;
            seq.st <= ST_VECTOR;
            seq.src <= SRC_SPI16;
            seq.ctrl.fetch_addr <= RESET_VECTOR;
            seq.ctrl.rom_mapping_select <= ROM_MAP_DEFAULT;
            seq.ctrl.pll_bypass <= 1'h1;
            seq.ctrl.clock_output_pin_enable <= 1'h1;
            seq.ctrl.scratch_reserved <= 1'h1;
            seq.ctrl.scratch_block <= SCRATCH_BLOCK;
            // R10, R13, R16, R17: probe bus settings and serial frame format
            seq.probe.chip_sel <= SPI_CHIP_SEL;
            seq.probe.target <= I2C_TARGET;
            seq.probe.bus_khz <= SPI_CLK_KHZ;
            seq.probe.baud <= UART_BAUD;
            seq.probe.data_bits <= UART_DATA_BITS;
            seq.probe.stop_bits <= UART_STOP_BITS;
            seq.probe.parity_odd <= UART_PARITY_ODD;
            seq.probe.flow_ctrl <= UART_FLOW_CTRL;
            seq.probe.endpoint <= USB_BOOT_EP;
        end
        else
        begin
            seq <= next_seq;
        end
    end

    assign ctrl = seq.ctrl;
    assign probe = seq.probe;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_vector_after_reset: assert property ( // R1
        $fell(sys_rst) |=> ctrl.vector_fetch && ctrl.fetch_addr == RESET_VECTOR
            && ctrl.pll_bypass && ctrl.rom_mapping_select == ROM_MAP_DEFAULT)
        else $error("no reset vector fetch after reset");
    a_pll_strap: assert property ( // R7
        seq.st == ST_CLOCK |=> (seq.clk_sel ? ctrl.pll_bypass
            : (!ctrl.pll_bypass && ctrl.pll_mult == PLL_MULT_RTC)))
        else $error("clock setup does not follow strap");
    a_clock_pin_off: assert property ( // R9
        ctrl.bandgap_trim_load |=> !ctrl.clock_output_pin_enable && seq.st == ST_PROBE)
        else $error("clock pin not stopped after trim");
    a_spi_probe: assert property ( // R10
        probe.req && probe.src == SRC_SPI16 |-> probe.chip_sel == SPI_CHIP_SEL
            && probe.bus_khz == SPI_CLK_KHZ && !probe.addr_24bit)
        else $error("spi probe settings wrong");
    a_i2c_probe: assert property ( // R13
        probe.req && probe.src == SRC_I2C |-> probe.target == I2C_TARGET
            && probe.bus_khz == I2C_CLK_KHZ)
        else $error("i2c probe settings wrong");
    a_probe_order: assert property ( // R3
        seq.st == ST_CHECK && !sig_match && seq.src < SRC_SD
            |=> seq.st == ST_PROBE ##1 probe.req && probe.src == rbds_src_e'($past(seq.src, 2) + 3'h1))
        else $error("probe order broken");
    a_first_wins: assert property ( // R4
        seq.st == ST_CHECK && sig_match |=> $stable(seq.src)
            && (ctrl.cfg_req || ctrl.copy_req))
        else $error("valid source not taken");
    a_config_first: assert property ( // R12
        seq.st == ST_CHECK && sig_match && feed.cfg_present |=> ctrl.cfg_req && !ctrl.copy_req)
        else $error("register section skipped");
    a_serial_fallback: assert property ( // R5
        seq.st == ST_CHECK && !sig_match && seq.src == SRC_SD |=> seq.st == ST_RETUNE
            ##1 ctrl.usb_ldo_en && !ctrl.pll_bypass
            && ctrl.pll_mult == (seq.clk_sel ? PLL_MULT_EXT_FAST : PLL_MULT_RTC_FAST))
        else $error("serial fallback not entered");
    a_serial_turns: assert property ( // R18
        seq.st == ST_CHECK && !sig_match && seq.src >= SRC_UART
            |=> seq.src != $past(seq.src) && seq.src >= SRC_UART)
        else $error("serial polling not alternating");
    a_jump_settled: assert property ( // R19
        ctrl.jump |-> settle_done && $past(seq.st) == ST_SETTLE)
        else $error("jump before settle time");
    a_clock_probed_only: assert property ( // R20
        ctrl.periph_clk != '0 |-> ctrl.periph_clk == periph_of(seq.src)
            && !(seq.st inside {ST_SETTLE, ST_DONE}))
        else $error("wrong peripheral clock on");
    a_handoff_quiet: assert property ( // R21
        ctrl.jump |-> ctrl.periph_clk == '0 && ctrl.periph_idle
            && ctrl.memory_port_idle && ctrl.hardware_accelerator_idle && !ctrl.scratch_reserved)
        else $error("handoff with live clocks or domains");
endmodule

// ---- testbench/rbds_mem_model.sv ----
`timescale 1ns/1ps
module rbds_mem_model
    import rbds_pkg::*;
#(
    parameter logic [15:0] SIG = 16'h3C96,
    parameter logic [23:0] ENTRY = 24'h012345
)(
    input wire logic clock,
    input wire rbds_probe_s probe,
    input wire rbds_ctrl_s ctrl,
    input wire rbds_src_e good_src,
    input wire logic good_en,
    input wire logic cfg_en,
    input wire logic [3:0] dly,
    output rbds_feed_s feed
);
    logic [15:0] hdr;
    // requests are seen as the design samples them, so a one-cycle pulse is never missed
    task automatic tick;
        @(posedge clock);
    endtask
    initial
    begin
        feed = '0;
        forever
        begin
            tick();
            feed.cfg_present <= cfg_en;
            if (probe.req)
            begin
                hdr = (good_en && probe.src == good_src) ? SIG : SIG ^ 16'h0100;
                repeat (dly) tick();
                feed.byte_valid <= 1'b1;
                feed.byte_data <= hdr[15:8];
                tick();
                feed.byte_data <= hdr[7:0];
                tick();
                // released line shows inverse of last byte
                feed.byte_valid <= 1'b0;
                feed.byte_data <= ~hdr[7:0];
                feed.probe_done <= 1'b1;
                tick();
                feed.probe_done <= 1'b0;
            end
            else if (ctrl.cfg_req)
            begin
                repeat (dly) tick();
                feed.cfg_done <= 1'b1;
                tick();
                feed.cfg_done <= 1'b0;
            end
            else if (ctrl.copy_req)
            begin
                repeat (dly) tick();
                feed.copy_done <= 1'b1;
                feed.entry_point <= ENTRY;
                tick();
                feed.copy_done <= 1'b0;
                feed.entry_point <= ~ENTRY;
            end
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import rbds_pkg::*;
    localparam int SET = 200;
    localparam logic [15:0] SIG = 16'h3C96;
    localparam logic [23:0] ENT = 24'h012345;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clock_source_select = 1'b0;
    rbds_feed_s feed;
    rbds_ctrl_s ctrl;
    rbds_probe_s probe;
    rbds_src_e good_src = SRC_SPI16;
    logic good_en = 1'b0;
    logic cfg_en = 1'b0;
    logic [3:0] dly = 4'h0;
    int n_mismatch = 0;
    int checks = 0;

    rbds_sequencer #(.SETTLE(SET), .BOOT_SIGNATURE(SIG)) dut (
        .clock(clock),
        .sys_rst(sys_rst),
        .clock_source_select(clock_source_select),
        .feed(feed),
        .ctrl(ctrl),
        .probe(probe)
    );
    rbds_mem_model #(.SIG(SIG), .ENTRY(ENT)) mem (
        .clock(clock),
        .probe(probe),
        .ctrl(ctrl),
        .good_src(good_src),
        .good_en(good_en),
        .cfg_en(cfg_en),
        .dly(dly),
        .feed(feed)
    );

    initial
    begin
        forever #5 clock = ~clock;
    end

    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
    endtask

    task automatic t_start;
        do_reset();
        @(negedge clock);
        cmp_val({ctrl.fetch_addr, ctrl.rom_mapping_select}, {24'hFFFF00, 1'b0});
        cmp_val({ctrl.pll_bypass, ctrl.clock_output_pin_enable}, 2'h3);
        cmp_val({ctrl.scratch_reserved, ctrl.scratch_block}, 6'h3F);
        @(negedge clock);
        cmp_val(ctrl.vector_fetch, 1'b1);
        @(negedge clock);
        cmp_val(ctrl.clock_output_pin_slow, 1'b1);
        @(negedge clock);
        cmp_val({ctrl.periph_idle, ctrl.memory_port_idle, ctrl.hardware_accelerator_idle},
            3'h7);
        @(negedge clock);
        cmp_val({ctrl.pll_bypass, ctrl.pll_mult}, {1'b0, 11'h177});
        cmp_val(ctrl.bandgap_trim_load, 1'b1);
        @(negedge clock);
        cmp_val(ctrl.clock_output_pin_enable, 1'b0);
        @(negedge clock);
        cmp_val({probe.req, probe.chip_sel, probe.bus_khz}, {1'b1, 2'h0, 10'h1F4});
    endtask

    // walks one boot; flip enables the good source in time for the flip-th serial probe
    task automatic run_boot(input int flip);
        rbds_src_e exp_s;
        rbds_src_e last;
        int n;
        int t0;
        int ncfg;
        int nser;
        logic [4:0] pc;
        exp_s = SRC_SPI16;
        last = SRC_SPI16;
        n = 0;
        t0 = 0;
        ncfg = 0;
        nser = 0;
        do_reset();
        while (ctrl.jump !== 1'b1)
        begin
            @(negedge clock);
            n++;
            if (n > 20000)
            begin
                n_mismatch++;
                end_sim();
            end
            if (ctrl.bandgap_trim_load)
            begin
                t0 = n;
                cmp_val(ctrl.pll_bypass, clock_source_select);
            end
            if (ctrl.cfg_req)
                ncfg++;
            if (ctrl.copy_req)
                cmp_val(ncfg, cfg_en);
            if (probe.req)
            begin
                pc = exp_s < SRC_I2C ? 5'h01 : exp_s == SRC_I2C ? 5'h02 :
                    exp_s < SRC_UART ? 5'h04 : exp_s == SRC_UART ? 5'h08 : 5'h10;
                cmp_val(probe.src, exp_s);
                cmp_val(ctrl.periph_clk, pc);
                cmp_val(probe.addr_24bit, exp_s == SRC_SPI24);
                if (exp_s == SRC_I2C)
                    cmp_val({probe.target, probe.bus_khz}, {7'h50, 10'h190});
                if (exp_s == SRC_UART)
                    cmp_val({probe.baud, probe.data_bits, probe.stop_bits, probe.parity_odd,
                        probe.flow_ctrl}, {17'h0E100, 4'h8, 2'h1, 2'h3});
                if (exp_s == SRC_UART && nser == 0)
                begin
                    t0 = n - 1;
                    cmp_val(ctrl.pll_mult, clock_source_select ? 11'h003 : 11'h465);
                end
                if (exp_s == SRC_USB)
                    cmp_val({ctrl.usb_ldo_en, probe.endpoint}, 5'h11);
                if (exp_s >= SRC_UART)
                    nser++;
                if (nser == flip)
                    good_en <= 1'b1;
                last = exp_s;
                exp_s = exp_s == SRC_UART ? SRC_USB : exp_s == SRC_USB ? SRC_UART :
                    rbds_src_e'(exp_s + 3'h1);
            end
        end
        cmp_val(last, good_src);
        cmp_val(n - t0 > SET, 1'b1);
        cmp_val(ctrl.jump_addr, ENT);
        cmp_val({ctrl.periph_clk, ctrl.periph_idle, ctrl.memory_port_idle,
            ctrl.hardware_accelerator_idle}, 8'h07);
        @(negedge clock);
        cmp_val({ctrl.scratch_reserved, probe.req}, 2'h0);
    endtask

    initial
    begin
        t_start();
        for (int s = 0; s < 6; s++)
        begin
            @(posedge clock);
            good_src <= rbds_src_e'(s);
            good_en <= 1'b1;
            cfg_en <= s[0];
            dly <= 4'(s * 3);
            clock_source_select <= s[1];
            run_boot(0);
        end
        @(posedge clock);
        good_src <= SRC_USB;
        good_en <= 1'b0;
        cfg_en <= 1'b1;
        clock_source_select <= 1'b1;
        run_boot(5);
        @(posedge clock);
        good_src <= SRC_UART;
        good_en <= 1'b0;
        clock_source_select <= 1'b0;
        run_boot(2);
        end_sim();
    end
endmodule
